// [rtl/adc_config_status_registers.sv]
`timescale 1ns/1ps
// Purpose: configuration and status register bank of the converter back end
// Assumes: APB slave, one wait state on every access
// Notes:   filter datapath is outside; only overrange and correction live here
module adc_config_status_registers
	import adc_regs_pkg::*;
#(
	parameter int         DATA_W  = 24,
	parameter logic [1:0] PART_ID = 2'h1, // arbitrary value
	parameter logic [2:0] DIE_ID  = 3'h2  // arbitrary value
) (
	input  wire logic                     clk_sys,
	input  wire logic                     reset,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic        [7:0]        paddr,
	input  wire logic        [31:0]       pwdata,
	output logic             [31:0]       prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire logic signed [DATA_W-1:0] stage1_data,
	input  wire logic                     stage1_valid,
	input  wire logic                     mod_sample,
	input  wire logic                     mod_beyond_ref,
	input  wire logic signed [DATA_W-1:0] filter_data,
	input  wire logic                     filter_valid,
	input  wire logic                     dl_done,
	input  wire logic        [15:0]       dl_calc_sum,
	input  wire logic        [15:0]       dl_host_sum,
	input  wire logic                     coef_check_done,
	input  wire logic        [15:0]       coef_calc_sum,
	input  wire logic                     custom_filter_in,
	output logic                          internal_clock,
	output logic                          full_power_off,
	output logic                          reduced_power_select,
	output logic                          input_amp_power_off,
	output logic                          over_threshold_flag,
	output logic                          fir_stage_skip,
	output logic                          first_stage_skip,
	output logic             [2:0]        rate_divide_select,
	output logic signed [DATA_W-1:0]      result_data,
	output logic                          result_valid,
	output logic                          output_valid_flag
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	logic [15:0]          ctrl2_q;
	logic [15:0]          offset_q;
	logic [15:0]          gain_q;
	logic [15:0]          thr_q;
	logic [C1_KEEP_W-1:0] cfg_q;
	read_sel_e            rd_sel_q;
	logic                 pready_q;
	logic                 pslverr_q;
	logic [31:0]          prdata_q;
	logic                 half_q;
	logic                 internal_clock_q;
	logic [2:0]           run_q;
	logic                 over_q;
	logic [15:0]          dl_sum_q;
	logic                 download_check_pass_q;
	logic                 coef_ok_q;
	logic                 custom_q;
	logic                 valid_flag_q;
	logic                 full_off_q;
	logic                 reduced_q;
	logic                 amp_off_q;

	logic                 access_w;
	logic [IDX_W-1:0]     idx_w;
	logic                 mapped_w;
	logic                 ro_w;
	logic                 wr_go;
	logic                 rd_go;
	logic [15:0]          status_w;
	logic [15:0]          reg_rd_w;
	logic [DATA_W-1:0]    mag_w;
	logic                 exceed_w;
	logic                 run_trip;

	corr_if #(.W(DATA_W)) cor ();

	// bus decode
	assign access_w = psel & penable;
	assign idx_w    = paddr[IDX_W+1:2];
	assign mapped_w = (paddr[1:0] == 2'h0) && (paddr[7:IDX_W+2] == '0) && (idx_w <= IDX_STATUS);
	assign ro_w     = (idx_w == IDX_RESULT) || (idx_w == IDX_STATUS);
	assign wr_go    = access_w & pready_q & pwrite & mapped_w & ~ro_w;
	assign rd_go    = access_w & pready_q & ~pwrite & mapped_w & (idx_w == IDX_RESULT);

	assign status_w = {PART_ID, DIE_ID, 1'b0, ctrl2_q[C2_REDUCED], over_q,
		download_check_pass_q, coef_ok_q, custom_q, cfg_q[C1_F3], cfg_q[C1_F1],
		cfg_q[RATE_W-1:0]};

	always_comb begin
		reg_rd_w = '0;
		unique case (idx_w)
			IDX_RESULT: begin
				unique case (rd_sel_q)
					RSEL_STATUS: reg_rd_w = status_w;
					RSEL_OFFSET: reg_rd_w = offset_q;
					RSEL_GAIN:   reg_rd_w = gain_q;
					RSEL_OVR:    reg_rd_w = thr_q;
					default:     reg_rd_w = '0;
				endcase
			end
			IDX_CTRL1:  reg_rd_w = 16'(cfg_q);
			IDX_CTRL2:  reg_rd_w = ctrl2_q;
			IDX_OFFSET: reg_rd_w = offset_q;
			IDX_GAIN:   reg_rd_w = gain_q;
			IDX_OVR:    reg_rd_w = thr_q;
			IDX_STATUS: reg_rd_w = status_w;
			default:    reg_rd_w = '0;
		endcase
	end

	// one wait state keeps prdata straight from a flop
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= '0;
		end else begin
			pready_q <= access_w & ~pready_q;
			if (access_w && !pready_q) begin
				pslverr_q <= ~mapped_w | (pwrite & ro_w);
				if (!pwrite && mapped_w && idx_w == IDX_RESULT && rd_sel_q == RSEL_RESULT)
					prdata_q <= 32'(unsigned'(result_data));
				else if (!pwrite && mapped_w)
					prdata_q <= 32'(reg_rd_w);
				else
					prdata_q <= '0;
			end else begin
				pslverr_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			ctrl2_q  <= CTRL2_RST;
			offset_q <= OFFSET_RST;
			gain_q   <= GAIN_RST;
			thr_q    <= OVR_RST;
		end else if (wr_go) begin
			unique case (idx_w)
				IDX_CTRL2:  ctrl2_q  <= pwdata[REG_W-1:0];
				IDX_OFFSET: offset_q <= pwdata[REG_W-1:0];
				IDX_GAIN:   gain_q   <= pwdata[REG_W-1:0];
				IDX_OVR:    thr_q    <= pwdata[REG_W-1:0];
				default: ;
			endcase
		end
	end

	// bits 15..9 self-clear, so only the low field is kept
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			cfg_q    <= CTRL1_RST[C1_KEEP_W-1:0];
			rd_sel_q <= RSEL_RESULT;
		end else if (wr_go && idx_w == IDX_CTRL1) begin
			cfg_q    <= pwdata[C1_KEEP_W-1:0];
			rd_sel_q <= sel_decode(pwdata[REG_W-1:0]);
		end else if (rd_go) begin
			rd_sel_q <= RSEL_RESULT;
		end
	end

	// internal clock as an enable; stopped while powered off
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			half_q <= 1'b0;
			internal_clock_q <= 1'b0;
		end else begin
			half_q <= ~half_q;
			internal_clock_q <= ~ctrl2_q[C2_OFF] & (ctrl2_q[C2_HALVE] | half_q);
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			full_off_q <= 1'b0;
			reduced_q  <= 1'b0;
			amp_off_q  <= 1'b0;
		end else begin
			full_off_q <= ctrl2_q[C2_OFF];
			reduced_q  <= ctrl2_q[C2_REDUCED];
			amp_off_q  <= ctrl2_q[C2_AMP];
		end
	end

	// threshold against the uncorrected first-stage magnitude
	assign mag_w    = stage1_data[DATA_W-1] ? DATA_W'(-stage1_data) : unsigned'(stage1_data);
	assign exceed_w = mag_w[DATA_W-1] | (mag_w[DATA_W-2 -: REG_W] > thr_q);
	assign run_trip = run_q > FULL_RUN;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset)
			run_q <= '0;
		else if (mod_sample)
			run_q <= !mod_beyond_ref ? 3'h0 : (&run_q ? run_q : run_q + 3'h1);
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset)
			over_q <= 1'b0;
		else if (run_trip)
			over_q <= 1'b1;
		else if (stage1_valid)
			over_q <= exceed_w;
	end

	// download checksum kept for the later in-filter comparison
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			dl_sum_q  <= '0;
			download_check_pass_q   <= 1'b0;
			coef_ok_q <= 1'b0;
			custom_q  <= 1'b0;
		end else begin
			custom_q <= custom_filter_in;
			if (dl_done) begin
				dl_sum_q <= dl_host_sum;
				download_check_pass_q  <= dl_calc_sum == dl_host_sum;
			end
			if (!custom_filter_in)
				coef_ok_q <= 1'b0;
			else if (coef_check_done)
				coef_ok_q <= coef_calc_sum == dl_sum_q;
		end
	end

	assign cor.en       = internal_clock_q;
	assign cor.in_valid = filter_valid;
	assign cor.in_data  = filter_data;
	assign cor.gain     = gain_q;
	assign cor.offset   = offset_q;

	gain_offset_corrector #(.W(DATA_W)) u_corr (
		.clk_sys (clk_sys),
		.reset   (reset),
		.c       (cor.dp)
	);

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset)
			valid_flag_q <= 1'b0;
		else if (cor.out_valid)
			valid_flag_q <= ~over_q;
	end

	assign prdata               = prdata_q;
	assign pready               = pready_q;
	assign pslverr              = pslverr_q;
	assign internal_clock       = internal_clock_q;
	assign full_power_off       = full_off_q;
	assign reduced_power_select = reduced_q;
	assign input_amp_power_off  = amp_off_q;
	assign over_threshold_flag  = over_q;
	assign fir_stage_skip       = cfg_q[C1_F3];
	assign first_stage_skip     = cfg_q[C1_F1];
	assign rate_divide_select   = cfg_q[RATE_W-1:0];
	assign result_data          = cor.out_data;
	assign result_valid         = cor.out_valid;
	assign output_valid_flag    = valid_flag_q;

	property p_defaults;
		$past(reset) |-> ctrl2_q == CTRL2_RST && gain_q == GAIN_RST && thr_q == OVR_RST
			&& offset_q == OFFSET_RST;
	endproperty
	a_defaults: assert property (p_defaults) else $error("reset defaults wrong");

	property p_halved;
		(!ctrl2_q[C2_HALVE] && !ctrl2_q[C2_OFF]) [*3] |-> internal_clock_q != $past(internal_clock_q);
	endproperty
	a_halved: assert property (p_halved) else $error("halved clock not alternating");

	property p_direct;
		(ctrl2_q[C2_HALVE] && !ctrl2_q[C2_OFF]) [*2] |-> internal_clock_q;
	endproperty
	a_direct: assert property (p_direct) else $error("direct clock missing");

	// sampled reset in the antecedent keeps the release edge out of these checks
	property p_off;
		!reset && ctrl2_q[C2_OFF] |=> !internal_clock_q && full_power_off;
	endproperty
	a_off: assert property (p_off) else $error("power-down not applied");

	property p_modes;
		!reset |=> reduced_power_select == $past(ctrl2_q[C2_REDUCED])
			&& input_amp_power_off == $past(ctrl2_q[C2_AMP]);
	endproperty
	a_modes: assert property (p_modes) else $error("power mode outputs wrong");

	property p_stat_rd;
		access_w && !pready_q && !pwrite && mapped_w && idx_w == IDX_STATUS |=> pready_q
			&& prdata_q[ST_ZERO] == 1'b0 && prdata_q[ST_REDUCED] == $past(ctrl2_q[C2_REDUCED]);
	endproperty
	a_stat_rd: assert property (p_stat_rd) else $error("status read wrong");

	property p_run;
		mod_sample && mod_beyond_ref && run_q == FULL_RUN |=> ##1 over_q;
	endproperty
	a_run: assert property (p_run) else $error("full-scale run missed");

	property p_thr;
		stage1_valid && exceed_w |=> over_q;
	endproperty
	a_thr: assert property (p_thr) else $error("threshold overrange missed");

	property p_valid;
		cor.out_valid && over_q |=> !output_valid_flag;
	endproperty
	a_valid: assert property (p_valid) else $error("valid flag not cleared");

	property p_rsel;
		wr_go && idx_w == IDX_CTRL1 && pwdata[C1_RD_STAT] |=> rd_sel_q == RSEL_STATUS;
	endproperty
	a_rsel: assert property (p_rsel) else $error("status select not armed");

	property p_dl;
		dl_done |=> download_check_pass_q == $past(dl_calc_sum == dl_host_sum);
	endproperty
	a_dl: assert property (p_dl) else $error("download check wrong");

	property p_coef;
		coef_check_done && custom_filter_in |=> coef_ok_q == $past(coef_calc_sum == dl_sum_q);
	endproperty
	a_coef: assert property (p_coef) else $error("coefficient check wrong");

	property p_custom;
		!reset |=> custom_q == $past(custom_filter_in);
	endproperty
	a_custom: assert property (p_custom) else $error("custom filter bit wrong");

	property p_mirror;
		wr_go && idx_w == IDX_CTRL1 |=> rate_divide_select == $past(pwdata[RATE_W-1:0])
			&& fir_stage_skip == $past(pwdata[C1_F3]) && first_stage_skip == $past(pwdata[C1_F1]);
	endproperty
	a_mirror: assert property (p_mirror) else $error("stage settings not mirrored");

	property p_ro_write;
		access_w && !pready_q && pwrite && idx_w == IDX_STATUS |=> pready_q && pslverr_q;
	endproperty
	a_ro_write: assert property (p_ro_write) else $error("status write not refused");
endmodule : adc_config_status_registers

// [inc/adc_regs_pkg.sv]
// Purpose: constants shared by the converter register bank and its correction stage
// Assumes: APB word access, each register in the low 16 bits of one aligned word, the result word in the low DATA_W bits
// Notes:   byte address of a register is four times its index
package adc_regs_pkg;
	localparam int          REG_W       = 16;
	localparam int          IDX_W       = 3;
	localparam logic [2:0]  IDX_RESULT  = 3'h0;
	localparam logic [2:0]  IDX_CTRL1   = 3'h1;
	localparam logic [2:0]  IDX_CTRL2   = 3'h2;
	localparam logic [2:0]  IDX_OFFSET  = 3'h3;
	localparam logic [2:0]  IDX_GAIN    = 3'h4;
	localparam logic [2:0]  IDX_OVR     = 3'h5;
	localparam logic [2:0]  IDX_STATUS  = 3'h6;
	localparam logic [15:0] CTRL1_RST   = 16'h001a;
	localparam logic [15:0] CTRL2_RST   = 16'h009b;
	localparam logic [15:0] CTRL2_NORM  = 16'h0002;
	localparam logic [15:0] OFFSET_RST  = 16'h0000;
	localparam logic [15:0] GAIN_RST    = 16'ha000;
	localparam logic [15:0] GAIN_UNITY  = 16'h8000;
	localparam logic [15:0] OVR_RST     = 16'hcccc;
	localparam int          C2_HALVE    = 5;
	localparam int          C2_OFF      = 3;
	localparam int          C2_REDUCED  = 2;
	localparam int          C2_ONE      = 1;
	localparam int          C2_AMP      = 0;
	localparam int          C1_RD_OVR   = 14;
	localparam int          C1_RD_GAIN  = 13;
	localparam int          C1_RD_OFF   = 12;
	localparam int          C1_RD_STAT  = 11;
	localparam int          C1_KEEP_W   = 9;
	localparam int          C1_F3       = 4;
	localparam int          C1_F1       = 3;
	localparam int          RATE_W      = 3;
	localparam int          ST_REDUCED  = 9;
	localparam int          ST_ZERO     = 10;
	localparam logic [2:0]  FULL_RUN    = 3'h4;
	localparam int          GAIN_FRAC   = 15;
	localparam int          OFFSET_LOSS = 23;
	typedef enum logic [2:0] {
		RSEL_RESULT = 3'b000,
		RSEL_STATUS = 3'b001,
		RSEL_OFFSET = 3'b010,
		RSEL_GAIN   = 3'b011,
		RSEL_OVR    = 3'b100
	} read_sel_e;
	// one read-select bit expected; lowest bit wins if the host breaks that
	function automatic read_sel_e sel_decode(input logic [15:0] w);
		if (w[C1_RD_STAT])
			return RSEL_STATUS;
		else if (w[C1_RD_OFF])
			return RSEL_OFFSET;
		else if (w[C1_RD_GAIN])
			return RSEL_GAIN;
		else if (w[C1_RD_OVR])
			return RSEL_OVR;
		return RSEL_RESULT;
	endfunction : sel_decode
endpackage : adc_regs_pkg

// [inc/corr_if.sv]
`timescale 1ns/1ps
// Purpose: carrier between register bank and gain/offset stage
// Assumes: one clock, en is the internal clock enable
// Notes:   ctl side feeds settings and data, dp side returns results
interface corr_if #(parameter int W = 24);
	logic                en;
	logic                in_valid;
	logic signed [W-1:0] in_data;
	logic        [15:0]  gain;
	logic        [15:0]  offset;
	logic                out_valid;
	logic signed [W-1:0] out_data;
	modport ctl (output en, in_valid, in_data, gain, offset, input out_valid, out_data);
	modport dp  (input en, in_valid, in_data, gain, offset, output out_valid, out_data);
endinterface : corr_if

// [rtl/gain_offset_corrector.sv]
`timescale 1ns/1ps
// Purpose: two-stage gain then offset correction of converter results
// Assumes: settings stable while a word passes through
// Notes:   two enabled cycles of latency, saturating output
module gain_offset_corrector
	import adc_regs_pkg::*;
#(
	parameter int W = 24
) (
	input  wire logic clk_sys,
	input  wire logic reset,
	corr_if.dp        c
);
	localparam int PW = W + 17;
	localparam int SW = PW + 1;
	localparam logic signed [SW-1:0] MAX_S = SW'((64'sd1 <<< (W - 1)) - 1);
	localparam logic signed [SW-1:0] MIN_S = SW'(-(64'sd1 <<< (W - 1)));

	function automatic logic signed [W-1:0] clip(input logic signed [SW-1:0] v);
		if (v > MAX_S)
			return MAX_S[W-1:0];
		else if (v < MIN_S)
			return MIN_S[W-1:0];
		return v[W-1:0];
	endfunction : clip

	logic signed [PW-1:0] scaled_q;
	logic                 mid_valid_q;
	logic signed [PW-1:0] prod_w;
	logic signed [SW-1:0] sum_w;
	logic signed [SW-1:0] off_w;

	// widen before multiplying, else the product is cut to the data width
	assign prod_w = (PW'(c.in_data) * PW'($signed({1'b0, c.gain}))) >>> GAIN_FRAC;
	// full offset code is 1/128 of full scale
	assign off_w = SW'($signed(c.offset)) <<< (W - OFFSET_LOSS);
	assign sum_w = SW'(scaled_q) + off_w;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			scaled_q    <= '0;
			mid_valid_q <= 1'b0;
		end else if (c.en) begin
			scaled_q    <= prod_w;
			mid_valid_q <= c.in_valid;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			c.out_data  <= '0;
			c.out_valid <= 1'b0;
		end else begin
			c.out_valid <= c.en & mid_valid_q;
			if (c.en && mid_valid_q)
				c.out_data <= clip(sum_w);
		end
	end
endmodule : gain_offset_corrector

// [tb/apb_host_model.sv]
// Purpose: APB host model issuing one register access at a time
// Assumes: slave raises pready within a bounded number of cycles
// Notes:   a wait that runs out counts a mismatch and ends the run
`timescale 1ns/1ps
module apb_host_model (
	input  wire logic        clk_sys,
	input  wire logic        pready,
	input  wire logic        pslverr,
	input  wire logic [31:0] prdata,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [7:0]  paddr,
	output logic      [31:0] pwdata
);
	initial begin
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h00000000;
	end

	task automatic xfer(input logic wr, input logic [7:0] a, input logic [15:0] d,
		output logic [15:0] q, output logic e);
		int          n;
		logic [15:0] v;
		n = 0;
		v = d;
		if (wr && a == 8'h08)
			v[1] = 1'b1;
		// a second read-select would leave the next read ambiguous
		if (wr && a == 8'h04 && $countones(v[14:11]) > 1)
			v[14:11] = 4'h0;
		@(posedge clk_sys);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= {16'h0000, v};
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 16);
		q = prdata[15:0];
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			test_adc_config_status_registers.miscompares++;
			test_adc_config_status_registers.summarize();
		end
	endtask : xfer
endmodule : apb_host_model

// [tb/test_adc_config_status_registers.sv]
// Purpose: self-checking bench for the converter register bank
// Assumes: host model speaks APB, bench drives the filter side
// Notes:   identity parameters carry arbitrary values
`timescale 1ns/1ps
module test_adc_config_status_registers;
	localparam logic [1:0] PID = 2'h2; // arbitrary value
	localparam logic [2:0] DID = 3'h5; // arbitrary value
	int                 miscompares = 0;
	int                 checks_done = 0;
	logic               clk_sys = 1'b0;
	logic               reset = 1'b1;
	logic               psel, penable, pwrite, pready, pslverr;
	logic        [7:0]  paddr;
	logic        [31:0] pwdata, prdata;
	logic signed [23:0] stage1_data = '0, filter_data = '0, result_data;
	logic               stage1_valid = 1'b0, mod_sample = 1'b0, mod_beyond_ref = 1'b0;
	logic               filter_valid = 1'b0, dl_done = 1'b0, coef_check_done = 1'b0;
	logic               custom_filter_in = 1'b0;
	logic        [15:0] dl_calc_sum = '0, dl_host_sum = '0, coef_calc_sum = '0;
	logic               internal_clock, full_power_off, reduced_power_select;
	logic               input_amp_power_off, over_threshold_flag, fir_stage_skip;
	logic               first_stage_skip, result_valid, output_valid_flag;
	logic        [2:0]  rate_divide_select;

	always #20 clk_sys = ~clk_sys;

	adc_config_status_registers #(
		.DATA_W (24),
		.PART_ID(PID),
		.DIE_ID (DID)
	) adc_config_status_registers_i (
		.clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .stage1_data, .stage1_valid, .mod_sample, .mod_beyond_ref,
		.filter_data, .filter_valid, .dl_done, .dl_calc_sum, .dl_host_sum,
		.coef_check_done, .coef_calc_sum, .custom_filter_in, .internal_clock,
		.full_power_off, .reduced_power_select, .input_amp_power_off,
		.over_threshold_flag, .fir_stage_skip, .first_stage_skip, .rate_divide_select,
		.result_data, .result_valid, .output_valid_flag
	);

	apb_host_model apb_host_model_i (
		.clk_sys, .pready, .pslverr, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata
	);

	task automatic summarize();
		if (miscompares == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : summarize

	task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] x);
		checks_done++;
		if (seen !== x) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", nm, x, seen);
		end
	endtask : check

	task automatic chk1(input string nm, input logic s, input logic x);
		check(nm, {23'h0, s}, {23'h0, x});
	endtask : chk1

	function automatic logic [15:0] st(input logic [4:0] mid, input logic [4:0] lo);
		return {PID, DID, 1'b0, mid, lo};
	endfunction : st

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [15:0] q;
		logic        e;
		apb_host_model_i.xfer(1'b1, a, d, q, e);
		chk1("write error", e, 1'b0);
	endtask : wr

	task automatic rdchk(input logic [7:0] a, input logic [15:0] x, input string nm);
		logic [15:0] q;
		logic        e;
		apb_host_model_i.xfer(1'b0, a, 16'h0000, q, e);
		check(nm, {8'h00, q}, {8'h00, x});
	endtask : rdchk

	task automatic icount(input int x, input string nm);
		int n;
		n = 0;
		repeat (10) begin
			@(posedge clk_sys);
			if (internal_clock === 1'b1)
				n++;
		end
		check(nm, n[23:0], x[23:0]);
	endtask : icount

	task automatic s1(input logic [23:0] x);
		@(posedge clk_sys);
		stage1_data  <= x;
		stage1_valid <= 1'b1;
		@(posedge clk_sys);
		stage1_valid <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask : s1

	task automatic corr(input logic [23:0] x, input logic [23:0] y, input logic v,
		input string nm);
		int n;
		n = 0;
		@(posedge clk_sys);
		filter_data  <= x;
		filter_valid <= 1'b1;
		do begin
			@(posedge clk_sys);
			filter_valid <= 1'b0;
			n++;
		end while (result_valid !== 1'b1 && n < 20);
		if (result_valid !== 1'b1) begin
			miscompares++;
			summarize();
		end else begin
			check(nm, result_data, y);
			@(posedge clk_sys);
			chk1("valid flag", output_valid_flag, v);
		end
	endtask : corr

	task automatic s_reset();
		rdchk(8'h0c, 16'h0000, "offset reset");
		rdchk(8'h10, 16'ha000, "gain reset");
		rdchk(8'h14, 16'hcccc, "threshold reset");
		rdchk(8'h08, 16'h009b, "ctrl2 reset");
		chk1("power off", full_power_off, 1'b1);
		chk1("amp off", input_amp_power_off, 1'b1);
		icount(0, "internal_clock in power-down");
	endtask : s_reset

	task automatic s_clock();
		wr(8'h08, 16'h0002);
		repeat (3) @(posedge clk_sys);
		icount(5, "internal_clock halved");
		chk1("power off", full_power_off, 1'b0);
		chk1("amp off", input_amp_power_off, 1'b0);
		wr(8'h08, 16'h0020);
		rdchk(8'h08, 16'h0022, "ctrl2 bit1");
		icount(10, "internal_clock full");
		wr(8'h08, 16'h0025);
		repeat (3) @(posedge clk_sys);
		chk1("reduced", reduced_power_select, 1'b1);
		chk1("amp off", input_amp_power_off, 1'b1);
		rdchk(8'h18, st(5'b10000, 5'h1a), "status low power");
		wr(8'h08, 16'h0008);
		repeat (3) @(posedge clk_sys);
		chk1("power off", full_power_off, 1'b1);
		chk1("reduced", reduced_power_select, 1'b0);
		icount(0, "internal_clock off");
		wr(8'h08, 16'h0022);
	endtask : s_clock

	task automatic s_status();
		logic [15:0] q;
		logic        e;
		wr(8'h04, 16'h001d);
		@(posedge clk_sys);
		dl_calc_sum      <= 16'h0e6b;
		dl_host_sum      <= 16'h0e6b;
		custom_filter_in <= 1'b1;
		coef_calc_sum    <= 16'h0e6b;
		dl_done          <= 1'b1;
		@(posedge clk_sys);
		dl_done         <= 1'b0;
		coef_check_done <= 1'b1;
		@(posedge clk_sys);
		coef_check_done <= 1'b0;
		rdchk(8'h18, st(5'b00111, 5'h1d), "status sums");
		chk1("f3 skip", fir_stage_skip, 1'b1);
		chk1("f1 skip", first_stage_skip, 1'b1);
		check("rate", {21'h0, rate_divide_select}, 24'h5);
		@(posedge clk_sys);
		dl_calc_sum      <= 16'h0e6a;
		custom_filter_in <= 1'b0;
		dl_done          <= 1'b1;
		@(posedge clk_sys);
		dl_done <= 1'b0;
		rdchk(8'h18, st(5'b00000, 5'h1d), "status no sums");
		apb_host_model_i.xfer(1'b1, 8'h18, 16'hffff, q, e);
		chk1("status write refused", e, 1'b1);
		apb_host_model_i.xfer(1'b0, 8'h1c, 16'h0000, q, e);
		chk1("unmapped", e, 1'b1);
		apb_host_model_i.xfer(1'b1, 8'h09, 16'h0000, q, e);
		chk1("misaligned", e, 1'b1);
		rdchk(8'h08, 16'h0022, "ctrl2 kept");
	endtask : s_status

	task automatic s_select();
		logic [15:0] x [4];
		x = '{16'h4000, 16'h8000, 16'h0010, st(5'b00000, 5'h1d)};
		wr(8'h0c, 16'h0010);
		wr(8'h10, 16'h8000);
		wr(8'h14, 16'h4000);
		// one select bit per write, 14 down to 11
		for (int i = 0; i < 4; i++) begin
			wr(8'h04, 16'h001d | (16'h4000 >> i));
			rdchk(8'h00, x[i], "read select");
		end
	endtask : s_select

	task automatic s_corr();
		wr(8'h0c, 16'h0000);
		corr(24'h001000, 24'h001000, 1'b1, "unity gain");
		wr(8'h10, 16'ha000);
		corr(24'h001000, 24'h001400, 1'b1, "gain 1.25");
		wr(8'h10, 16'h4000);
		wr(8'h0c, 16'h0100);
		corr(24'h001000, 24'h000a00, 1'b1, "gain then offset");
		wr(8'h10, 16'h8000);
		wr(8'h0c, 16'h7fff);
		corr(24'h000000, 24'h00fffe, 1'b1, "offset max");
		wr(8'h0c, 16'h8000);
		corr(24'h000000, 24'hff0000, 1'b1, "offset min");
		wr(8'h0c, 16'h0000);
		wr(8'h10, 16'hffff);
		corr(24'h7fffff, 24'h7fffff, 1'b1, "sat high");
		corr(24'h800000, 24'h800000, 1'b1, "sat low");
		wr(8'h10, 16'h8000);
	endtask : s_corr

	task automatic s_ovr();
		s1(24'h600000);
		chk1("ovr high", over_threshold_flag, 1'b1);
		rdchk(8'h18, st(5'b01000, 5'h1d), "status ovr");
		corr(24'h001000, 24'h001000, 1'b0, "word in ovr");
		s1(24'h001000);
		chk1("ovr clear", over_threshold_flag, 1'b0);
		s1(24'ha00000);
		chk1("ovr negative", over_threshold_flag, 1'b1);
		s1(24'h001000);
		corr(24'h001000, 24'h001000, 1'b1, "word clear");
	endtask : s_ovr

	task automatic s_modref();
		@(posedge clk_sys);
		mod_beyond_ref <= 1'b1;
		mod_sample     <= 1'b1;
		repeat (4) @(posedge clk_sys);
		mod_beyond_ref <= 1'b0;
		@(posedge clk_sys);
		mod_sample <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk1("four beyond", over_threshold_flag, 1'b0);
		mod_beyond_ref <= 1'b1;
		mod_sample     <= 1'b1;
		repeat (5) @(posedge clk_sys);
		mod_beyond_ref <= 1'b0;
		mod_sample     <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk1("five beyond", over_threshold_flag, 1'b1);
	endtask : s_modref

	initial begin
		repeat (20) @(posedge clk_sys);
		reset <= 1'b0;
		s_reset();
		s_clock();
		s_status();
		s_select();
		s_corr();
		s_ovr();
		s_modref();
		summarize();
	end
endmodule : test_adc_config_status_registers
